// ---- design/exec_pkg.sv ----
package exec_pkg;

    // Operation codes presented by the dispatch stage.
    typedef enum logic [2:0]
    {
        OP_NONE = 3'b000,
        OP_UNPACK_HIGH = 3'b001,
        OP_UNPACK_LOW = 3'b010,
        OP_XOR = 3'b011,
        OP_GALOIS_MPY = 3'b100,
        OP_MASK_EXPAND = 3'b101,
        OP_SW_EXC_NO_RETURN = 3'b110
    } op_e;

    localparam int WORD_W = 32;
    localparam int REG_ADDR_W = 5;
    localparam int CONST_W = 5;
    localparam int MPY_SRC2_W = 9;
    localparam int MPY_EXTEND_W = 8;
    localparam int HALF_W = 16;
    // Result latency in cycles after the issue edge.
    localparam int LAT_SINGLE = 1;
    localparam int LAT_EXPAND = 2;
    localparam int LAT_MPY = 4;
    localparam int PIPE_DEPTH = 4;
    // Values after reset.
    localparam logic RST_FLAG = 1'b0;
    localparam logic [WORD_W-1:0] RST_WORD = 32'h0000_0000;

endpackage

// ---- design/galois_if.sv ----
`timescale 1ns/1ps
// Operand and product path between the execute unit and its multiplier.
interface galois_if;
    logic [31:0] multiplicand;
    logic [8:0] multiplier;
    logic [31:0] product;
    modport requester (output multiplicand, output multiplier, input product);
    modport multiplier_end (input multiplicand, input multiplier, output product);
endinterface

// ---- design/galois_zero_poly.sv ----
`timescale 1ns/1ps
// Carry-less multiply with a zero polynomial; pure combinational.
module galois_zero_poly
(
    galois_if.multiplier_end gp
);
    import exec_pkg::*;

    logic [WORD_W+MPY_EXTEND_W-1:0] acc;

    // Every partial level folds into one chain, so the full product is 40 bits wide.
    always_comb
    begin
        acc = '0;
        for (int i = 0; i < MPY_SRC2_W; i++)
        begin
            if (gp.multiplier[i])
            begin
                acc = acc ^ ({8'h00, gp.multiplicand} << i);
            end
        end
    end

    // The register holds 32 bits, so the 8 extended bits fall away on write.
    assign gp.product = acc[WORD_W-1:0];

endmodule

// ---- design/packed_unpack_mask_xor_unit.sv ----
`timescale 1ns/1ps
module packed_unpack_mask_xor_unit
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic issue_valid,
    input wire exec_pkg::op_e issue_op,
    input wire logic predicate_true,
    input wire logic src1_is_const,
    input wire logic [31:0] src1,
    input wire logic [4:0] signed_five_bit_constant,
    input wire logic [31:0] src2,
    input wire logic [4:0] dst_addr,
    input wire logic [31:0] galois_polynomial_register,
    input wire logic other_exception,
    output logic wb_valid,
    output logic [4:0] wb_addr,
    output logic [31:0] wb_data,
    output logic software_exception_flag,
    output logic hardware_exception_bit,
    output logic take_no_return_entry,
    output logic take_nmi_entry,
    output logic save_return_state
);
    import exec_pkg::*;

    logic rst_sync1_q;
    logic rst_sync2_q;
    logic rst_n;
    logic [31:0] xor_src1;
    logic [31:0] single_result;
    logic single_write;
    logic [31:0] expand_result;
    logic [31:0] mpy_product;
    logic [31:0] poly_unused;
    logic software_exception_no_return_issue;
    logic [PIPE_DEPTH-1:0] pipe_valid_q;
    logic [4:0] pipe_addr_q [PIPE_DEPTH];
    logic [31:0] pipe_data_q [PIPE_DEPTH];
    logic [PIPE_DEPTH-1:0] mpy_valid_q;
    logic [4:0] mpy_addr_q [PIPE_DEPTH];

    galois_if gbus ();

    // Reset is released through two flops so every process leaves it on one edge.
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_sync1_q <= 1'b0;
            rst_sync2_q <= 1'b0;
        end
        else
        begin
            rst_sync1_q <= 1'b1;
            rst_sync2_q <= rst_sync1_q;
        end
    end
    assign rst_n = rst_sync2_q;

    // The polynomial input is deliberately not connected to any arithmetic.
    assign poly_unused = galois_polynomial_register;
    assign gbus.multiplicand = src1;
    assign gbus.multiplier = src2[MPY_SRC2_W-1:0];
    assign mpy_product = gbus.product;

    galois_zero_poly u_gmpy
    (
        .gp(gbus.multiplier_end)
    );

    // The constant form sign-extends before the exclusive-OR.
    assign xor_src1 = src1_is_const ?
        {{(WORD_W-CONST_W){signed_five_bit_constant[CONST_W-1]}}, signed_five_bit_constant}
        : src1;

    // Only the two lowest source bits are looked at.
    assign expand_result = {{HALF_W{src2[1]}}, {HALF_W{src2[0]}}};

    // Single-cycle results are formed here and written at the next edge.
    always_comb
    begin
        single_result = RST_WORD;
        single_write = 1'b0;
        case (issue_op)
            OP_UNPACK_HIGH:
            begin
                single_result = {8'h00, src2[31:24], 8'h00, src2[23:16]};
                single_write = 1'b1;
            end
            OP_UNPACK_LOW:
            begin
                single_result = {8'h00, src2[15:8], 8'h00, src2[7:0]};
                single_write = 1'b1;
            end
            OP_XOR:
            begin
                single_result = xor_src1 ^ src2;
                single_write = 1'b1;
            end
            default:
            begin
                single_result = RST_WORD;
                single_write = 1'b0;
            end
        endcase
    end

    // The no-return exception runs unconditionally; the predicate does not gate it.
    assign software_exception_no_return_issue = issue_valid && (issue_op == OP_SW_EXC_NO_RETURN);

    // Multi-cycle stages; a false predicate never sets a stage valid bit, though address and data still load.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pipe_valid_q <= '0;
            for (int i = 0; i < PIPE_DEPTH; i++)
            begin
                pipe_addr_q[i] <= '0;
                pipe_data_q[i] <= RST_WORD;
            end
        end
        else
        begin
            // Stage 0 carries single-cycle work, stage 1 carries mask expansion.
            pipe_valid_q[0] <= issue_valid && predicate_true && single_write;
            pipe_addr_q[0] <= dst_addr;
            pipe_data_q[0] <= single_result;
            pipe_valid_q[1] <= issue_valid && predicate_true
                && (issue_op == OP_MASK_EXPAND);
            pipe_addr_q[1] <= dst_addr;
            pipe_data_q[1] <= expand_result;
            pipe_valid_q[2] <= pipe_valid_q[1];
            pipe_addr_q[2] <= pipe_addr_q[1];
            pipe_data_q[2] <= pipe_data_q[1];
            pipe_valid_q[3] <= 1'b0;
            pipe_addr_q[3] <= '0;
            pipe_data_q[3] <= RST_WORD;
        end
    end

    // Multiply product is captured at issue and walks two more stages before the write-back register.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mpy_valid_q <= '0;
            for (int i = 0; i < PIPE_DEPTH; i++)
            begin
                mpy_addr_q[i] <= '0;
            end
        end
        else
        begin
            mpy_valid_q <= {mpy_valid_q[PIPE_DEPTH-2:0],
                issue_valid && predicate_true && (issue_op == OP_GALOIS_MPY)};
            mpy_addr_q[0] <= dst_addr;
            for (int i = 1; i < PIPE_DEPTH; i++)
            begin
                mpy_addr_q[i] <= mpy_addr_q[i-1];
            end
        end
    end

    logic [31:0] mpy_data_q [PIPE_DEPTH];

    // Product data shifts alongside its valid bits.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < PIPE_DEPTH; i++)
            begin
                mpy_data_q[i] <= RST_WORD;
            end
        end
        else
        begin
            mpy_data_q[0] <= mpy_product;
            for (int i = 1; i < PIPE_DEPTH; i++)
            begin
                mpy_data_q[i] <= mpy_data_q[i-1];
            end
        end
    end

    // Write-back port; issue timing by software avoids two results in one cycle.
    // If they collide anyway the oldest instruction, the multiply, wins.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wb_valid <= 1'b0;
            wb_addr <= '0;
            wb_data <= RST_WORD;
        end
        else if (mpy_valid_q[LAT_MPY-2])
        begin
            wb_valid <= 1'b1;
            wb_addr <= mpy_addr_q[LAT_MPY-2];
            wb_data <= mpy_data_q[LAT_MPY-2];
        end
        else if (pipe_valid_q[LAT_EXPAND-1] && !pipe_valid_q[0])
        begin
            wb_valid <= 1'b1;
            wb_addr <= pipe_addr_q[LAT_EXPAND-1];
            wb_data <= pipe_data_q[LAT_EXPAND-1];
        end
        else
        begin
            wb_valid <= issue_valid && predicate_true && single_write;
            wb_addr <= dst_addr;
            wb_data <= single_result;
        end
    end

    // Flag effects land one cycle after issue and are sticky until reset.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            software_exception_flag <= RST_FLAG;
            hardware_exception_bit <= RST_FLAG;
        end
        else if (software_exception_no_return_issue)
        begin
            software_exception_flag <= 1'b1;
            hardware_exception_bit <= 1'b0;
        end
    end

    // Entry selection; a coincident other exception takes the normal path.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            take_no_return_entry <= 1'b0;
            take_nmi_entry <= 1'b0;
            save_return_state <= 1'b0;
        end
        else
        begin
            take_no_return_entry <= software_exception_no_return_issue && !other_exception;
            take_nmi_entry <= other_exception;
            save_return_state <= other_exception;
        end
    end

endmodule

// ---- verif/packed_unpack_mask_xor_unit_assertions.sv ----
`timescale 1ns/1ps
// Ties every write and exception output to the issue that caused it.
module unit_checker
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic issue_valid,
    input wire exec_pkg::op_e issue_op,
    input wire logic predicate_true,
    input wire logic src1_is_const,
    input wire logic [31:0] src1,
    input wire logic [4:0] signed_five_bit_constant,
    input wire logic [31:0] src2,
    input wire logic [4:0] dst_addr,
    input wire logic other_exception,
    input wire logic wb_valid,
    input wire logic [4:0] wb_addr,
    input wire logic [31:0] wb_data,
    input wire logic software_exception_flag,
    input wire logic hardware_exception_bit,
    input wire logic take_no_return_entry,
    input wire logic take_nmi_entry,
    input wire logic save_return_state
);
    import exec_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    // An operation other than the no-return exception is taken only with a true predicate.
    sequence s_take(op_e o);
        issue_valid && predicate_true && issue_op == o;
    endsequence
    sequence s_exc;
        issue_valid && issue_op == OP_SW_EXC_NO_RETURN;
    endsequence

    a_unpack_high_data: assert property (s_take(OP_UNPACK_HIGH) |=> wb_valid &&
        wb_data == {8'h00, $past(src2[31:24]), 8'h00, $past(src2[23:16])})
        else $error("high unpack");
    a_unpack_low_data: assert property (s_take(OP_UNPACK_LOW) |=> wb_valid &&
        wb_data == {8'h00, $past(src2[15:8]), 8'h00, $past(src2[7:0])})
        else $error("low unpack");
    a_xor_data: assert property (s_take(OP_XOR) |=> wb_valid && wb_data ==
        ($past(src1_is_const ? {{27{signed_five_bit_constant[4]}}, signed_five_bit_constant}
        : src1) ^ $past(src2))) else $error("xor result");
    a_expand_mask_data: assert property (s_take(OP_MASK_EXPAND) |=>
        !wb_valid ##1 wb_valid && wb_data == {{16{$past(src2[1], 2)}}, {16{$past(src2[0], 2)}}})
        else $error("mask expand");
    a_mpy_write_slot: assert property (s_take(OP_GALOIS_MPY) |=> !wb_valid [*3] ##1
        wb_valid && wb_addr == $past(dst_addr, 4)) else $error("multiply latency");
    a_false_pred_quiet: assert property (issue_valid && !predicate_true &&
        issue_op inside {OP_UNPACK_HIGH, OP_UNPACK_LOW, OP_XOR} |=> !wb_valid)
        else $error("false write");
    a_exc_flag_update: assert property (s_exc |=> software_exception_flag &&
        !hardware_exception_bit) else $error("exception flags");
    a_flag_stays_set: assert property (software_exception_flag |=> software_exception_flag)
        else $error("flag dropped");
    a_other_exc_wins: assert property (other_exception |=> take_nmi_entry &&
        save_return_state && !take_no_return_entry) else $error("priority lost");
    a_no_return_entry: assert property (s_exc ##0 !other_exception |=>
        take_no_return_entry && !take_nmi_entry) else $error("no-return entry");
endmodule

bind packed_unpack_mask_xor_unit unit_checker chk (.*);

// ---- verif/regfile_model.sv ----
`timescale 1ns/1ps
// Far-side register file; holds every word the unit writes back.
module regfile_model
(
    input wire logic sys_clk,
    input wire logic wb_valid,
    input wire logic [4:0] wb_addr,
    input wire logic [31:0] wb_data
);
    logic [31:0] regs [32];

    // Preset words so that a stray write cannot go unnoticed.
    initial
    begin
        for (int i = 0; i < 32; i++)
            regs[i] = 32'ha5a5_0000 | 32'(i);
    end

    // Writes land on the clock edge that sees the strobe.
    always @(posedge sys_clk)
    begin
        if (wb_valid)
            regs[wb_addr] <= wb_data;
    end
endmodule

// ---- verif/test_packed_unpack_mask_xor_unit.sv ----
`timescale 1ns/1ps
// Issues each operation at the falling edge and judges the write port.
module test_packed_unpack_mask_xor_unit;
    import exec_pkg::*;
    logic sys_clk, rstn = 1'b0, issue_valid = 1'b0, predicate_true = 1'b0;
    logic src1_is_const = 1'b0, other_exception = 1'b0;
    op_e issue_op = OP_NONE;
    logic [31:0] src1 = 32'h0, src2 = 32'h0, galois_polynomial_register = 32'h0;
    logic [4:0] signed_five_bit_constant = 5'h0, dst_addr = 5'h0, wb_addr;
    logic wb_valid, software_exception_flag, hardware_exception_bit;
    logic take_no_return_entry, take_nmi_entry, save_return_state;
    logic [31:0] wb_data;
    int fails = 0, check_count = 0, cycles = 0;

    packed_unpack_mask_xor_unit dut (.*);
    regfile_model rf (.*);

    // Free-running system clock.
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task close_out;
        $display("Comparisons %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task chk_bit(string what, logic exp, logic got);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask

    task chk_word(string what, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Carry-less product, nine multiplier bits, cut to one word.
    function automatic logic [31:0] clmul9(logic [31:0] a, logic [8:0] b);
        logic [31:0] r;
        r = 32'h0;
        for (int i = 0; i < 9; i++)
            if (b[i])
                r ^= a << i;
        return r;
    endfunction

    // One issue, then the write must appear exactly lat cycles on.
    task run_op(op_e op, logic [31:0] a, logic [31:0] b, logic pred, int lat, logic [31:0] exp);
        issue_valid = 1'b1;
        issue_op = op;
        src1 = a;
        src2 = b;
        signed_five_bit_constant = a[4:0];
        predicate_true = pred;
        for (int i = 1; i <= lat; i++)
        begin
            @(negedge sys_clk);
            issue_valid = 1'b0;
            if (i < lat)
                chk_bit("early write", 1'b0, wb_valid);
        end
        chk_bit("write strobe", pred, wb_valid);
        if (pred)
        begin
            chk_word("write data", exp, wb_data);
            chk_word("write address", {27'h0, dst_addr}, {27'h0, wb_addr});
        end
        @(negedge sys_clk);
        chk_bit("strobe drop", 1'b0, wb_valid);
    endtask

    task t_unpack_xor;
        dst_addr = 5'h02;
        run_op(OP_UNPACK_HIGH, 32'h0, 32'h9e52_6e30, 1'b1, 1, 32'h009e_0052);
        run_op(OP_UNPACK_LOW, 32'h0, 32'h1105_6934, 1'b1, 1, 32'h0069_0034);
        run_op(OP_XOR, 32'h0721_325a, 32'h0019_0f12, 1'b1, 1, 32'h0738_3d48);
        src1_is_const = 1'b1;
        run_op(OP_XOR, 32'h0000_001d, 32'h0000_1023, 1'b1, 1, 32'hffff_efde);
        run_op(OP_XOR, 32'hffff_ff0d, 32'h0000_1023, 1'b1, 1, 32'h0000_102e);
        src1_is_const = 1'b0;
    endtask

    task t_mpy_expand;
        logic [31:0] mask;
        dst_addr = 5'h04;
        galois_polynomial_register = 32'hffff_ffff;
        run_op(OP_GALOIS_MPY, 32'h1234_5678, 32'hffff_ff26, 1'b1, 4,
            32'h1e65_4210);
        run_op(OP_GALOIS_MPY, '1, 32'h0000_01ff, 1'b1, 4, clmul9('1, 9'h1ff));
        for (int v = 0; v < 4; v++)
        begin
            mask = {{16{v[1]}}, {16{v[0]}}};
            run_op(OP_MASK_EXPAND, 32'h0, 32'hffff_fffc | 32'(v), 1'b1, 2,
                mask);
        end
    endtask

    task t_pred;
        dst_addr = 5'h07;
        run_op(OP_XOR, 32'h1, 32'h2, 1'b1, 1, 32'h3);
        run_op(OP_UNPACK_HIGH, '1, '1, 1'b0, 1, 32'h0);
        run_op(OP_UNPACK_LOW, '1, '1, 1'b0, 1, 32'h0);
        run_op(OP_XOR, '1, '1, 1'b0, 1, 32'h0);
        run_op(OP_MASK_EXPAND, '1, '1, 1'b0, 2, 32'h0);
        run_op(OP_GALOIS_MPY, '1, '1, 1'b0, 4, 32'h0);
        chk_word("kept word", 32'h3, rf.regs[7]);
    endtask

    task t_exception;
        issue_valid = 1'b1;
        issue_op = OP_SW_EXC_NO_RETURN;
        predicate_true = 1'b0;
        @(negedge sys_clk);
        issue_valid = 1'b0;
        chk_bit("software flag", 1'b1, software_exception_flag);
        chk_bit("hardware bit", 1'b0, hardware_exception_bit);
        chk_bit("no-return entry", 1'b1, take_no_return_entry);
        chk_bit("nmi idle", 1'b0, take_nmi_entry);
        @(negedge sys_clk);
        issue_valid = 1'b1;
        other_exception = 1'b1;
        @(negedge sys_clk);
        issue_valid = 1'b0;
        other_exception = 1'b0;
        chk_bit("nmi entry", 1'b1, take_nmi_entry);
        chk_bit("state saved", 1'b1, save_return_state);
        chk_bit("no-return held off", 1'b0, take_no_return_entry);
    endtask

    // A hung run is cut short here and judged as failed.
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 1000)
        begin
            fails++;
            $display("[ERR] run length expected below 1000 seen %0d", cycles);
            close_out();
        end
    end

    // Reset, wait out the internal release, then run every scenario.
    initial
    begin
        repeat (4) @(negedge sys_clk);
        rstn = 1'b1;
        repeat (3) @(negedge sys_clk);
        t_unpack_xor();
        t_mpy_expand();
        t_pred();
        t_exception();
        close_out();
    end
endmodule
